// file: ebr_map.svh
// constants of the embedded block ram
`ifndef EBR_MAP_SVH
`define EBR_MAP_SVH
`define EBR_TOTAL_BITS 4608
`define EBR_PARITY_BITS 512
`define EBR_ROWS 128
`define EBR_ROW_W 36
`define EBR_ROW_AW 7
`define EBR_HALF_AW 6
`define EBR_LANES 4
`define EBR_LANE_W 9
`define EBR_BYTE_W 8
`define EBR_DATA_W 32
`define EBR_ADDR_W 12
`define EBR_PORTS 2
`define EBR_MASK_MIN_W 16
`define EBR_RATED_MHZ 200
`define EBR_CLK_MHZ 250
`define EBR_BE_RST 4'hF
`define EBR_DOUT_RST 36'h0
`endif

// file: ebr_pkg.sv
// types of the embedded block ram
`default_nettype none
`include "ebr_map.svh"
package ebr_pkg;
   typedef enum logic [3:0] {
      EBR_X1 = 4'h0,
      EBR_X2 = 4'h1,
      EBR_X4 = 4'h2,
      EBR_X8 = 4'h3,
      EBR_X16 = 4'h4,
      EBR_X32 = 4'h5,
      EBR_X9 = 4'h6,
      EBR_X18 = 4'h7,
      EBR_X36 = 4'h8
   } ebr_width_type;
   typedef struct packed {
      logic [`EBR_ADDR_W-1:0] addr;
      logic [`EBR_ROW_W-1:0] din;
      logic wren;
      logic rden;
      logic [`EBR_LANES-1:0] byteena;
   } ebr_req_type;
   typedef struct packed {
      ebr_width_type width;
      logic split;
      logic out_reg;
   } ebr_cfg_type;
endpackage
`default_nettype wire

// file: ebr_sp.sv
// single-port embedded block ram, splittable into two half-size rams
`default_nettype none
`include "ebr_map.svh"
module ebr_sp (
   input wire logic clk,
   input wire logic resetn,
   input wire ebr_pkg::ebr_cfg_type cfg,
   input wire ebr_pkg::ebr_req_type [`EBR_PORTS-1:0] req,
   input wire logic [`EBR_PORTS-1:0] clr_in,
   input wire logic [`EBR_PORTS-1:0] clr_out,
   output logic [`EBR_PORTS-1:0][`EBR_ROW_W-1:0] dout
);

   // single clock, no multicycle paths inside

   logic [1:0] rst_q;
   logic rst_n;
   ebr_pkg::ebr_req_type [`EBR_PORTS-1:0] req_q;
   ebr_pkg::ebr_req_type [`EBR_PORTS-1:0] req_d;
   logic [`EBR_PORTS-1:0][`EBR_ROW_W-1:0] hold_q;
   logic [`EBR_PORTS-1:0][`EBR_ROW_W-1:0] hold_d;
   logic [`EBR_PORTS-1:0][`EBR_ROW_W-1:0] out_q;
   logic [`EBR_PORTS-1:0][`EBR_ROW_W-1:0] out_d;
   logic [`EBR_PORTS-1:0][`EBR_ROW_W-1:0] comb_val;
   logic [`EBR_PORTS-1:0][`EBR_ROW_W-1:0] new_row;
   logic [`EBR_PORTS-1:0][`EBR_ROW_AW-1:0] row;
   logic [`EBR_PORTS-1:0] we;
   logic [5:0] shape_bits;
   logic [2:0] shape_lg;
   logic shape_par;
   logic lane_ok;
   logic [`EBR_ROW_W-1:0] word_mask;
   logic [`EBR_PORTS-1:0][5:0] pos;
   logic [`EBR_PORTS-1:0][`EBR_LANES-1:0] be_eff;
   logic [`EBR_PORTS-1:0][`EBR_ROW_W-1:0] mask;
   logic [`EBR_PORTS-1:0][`EBR_ROW_W-1:0] data;
   logic [`EBR_ROW_W-1:0] mem_q [`EBR_ROWS];

   // width of one word in bits
   function automatic logic [5:0] word_bits(input ebr_pkg::ebr_width_type w);
      logic [5:0] r;
      r = 6'h1;
      unique case (w)
         ebr_pkg::EBR_X1: r = 6'h01;
         ebr_pkg::EBR_X2: r = 6'h02;
         ebr_pkg::EBR_X4: r = 6'h04;
         ebr_pkg::EBR_X8: r = 6'h08;
         ebr_pkg::EBR_X16: r = 6'h10;
         ebr_pkg::EBR_X32: r = 6'h20;
         ebr_pkg::EBR_X9: r = 6'h09;
         ebr_pkg::EBR_X18: r = 6'h12;
         ebr_pkg::EBR_X36: r = 6'h24;
         default: r = 6'h01;
      endcase
      return r;
   endfunction

   // log2 of words per row
   function automatic logic [2:0] per_row_lg(input ebr_pkg::ebr_width_type w);
      logic [2:0] r;
      r = 3'h0;
      unique case (w)
         ebr_pkg::EBR_X1: r = 3'h5;
         ebr_pkg::EBR_X2: r = 3'h4;
         ebr_pkg::EBR_X4: r = 3'h3;
         ebr_pkg::EBR_X8: r = 3'h2;
         ebr_pkg::EBR_X16: r = 3'h1;
         ebr_pkg::EBR_X32: r = 3'h0;
         ebr_pkg::EBR_X9: r = 3'h2;
         ebr_pkg::EBR_X18: r = 3'h1;
         ebr_pkg::EBR_X36: r = 3'h0;
         default: r = 3'h0;
      endcase
      return r;
   endfunction

   // shapes that use the parity bits as data
   function automatic logic uses_parity(input ebr_pkg::ebr_width_type w);
      return (w == ebr_pkg::EBR_X9) || (w == ebr_pkg::EBR_X18) || (w == ebr_pkg::EBR_X36);
   endfunction

   // place byte k of a data word in lane k, parity bit left zero
   function automatic logic [`EBR_ROW_W-1:0] spread(input logic [`EBR_DATA_W-1:0] v);
      logic [`EBR_ROW_W-1:0] r;
      r = '0;
      for (int i = 0; i < `EBR_LANES; i++) begin
         r[i*`EBR_LANE_W +: `EBR_LANE_W] = {1'b0, v[i*`EBR_BYTE_W +: `EBR_BYTE_W]};
      end
      return r;
   endfunction

   // drop the parity bit of each lane
   function automatic logic [`EBR_DATA_W-1:0] squeeze(input logic [`EBR_ROW_W-1:0] v);
      logic [`EBR_DATA_W-1:0] r;
      r = '0;
      for (int i = 0; i < `EBR_LANES; i++) begin
         r[i*`EBR_BYTE_W +: `EBR_BYTE_W] = v[i*`EBR_LANE_W +: `EBR_BYTE_W];
      end
      return r;
   endfunction

   // expand lane enables to a nine-bit-per-lane mask
   function automatic logic [`EBR_ROW_W-1:0] lane_mask(input logic [`EBR_LANES-1:0] be);
      logic [`EBR_ROW_W-1:0] r;
      r = '0;
      for (int i = 0; i < `EBR_LANES; i++) begin
         r[i*`EBR_LANE_W +: `EBR_LANE_W] = {`EBR_LANE_W{be[i]}};
      end
      return r;
   endfunction

   // reset release through two flops
   logic [1:0] rst_d;
   always_comb begin
      rst_d = {rst_q[0], 1'b1};
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= rst_d;
      end
   end
   assign rst_n = rst_q[1];

   // shape decode shared by both ports
   always_comb begin
      shape_bits = word_bits(cfg.width);
      shape_lg = per_row_lg(cfg.width);
      shape_par = uses_parity(cfg.width);
      word_mask = (`EBR_ROW_W'(1) << shape_bits) - `EBR_ROW_W'(1);
      lane_ok = shape_bits >= 6'(`EBR_MASK_MIN_W);
   end

   // next value of the input registers
   always_comb begin
      for (int p = 0; p < `EBR_PORTS; p++) begin
         // request captured on the edge; port 1 strobes only when split, except that clr_in[1] sets its read strobe in either mode
         req_d[p] = req[p];
         if (p != 0 && !cfg.split) begin
            req_d[p].wren = 1'b0;
            req_d[p].rden = 1'b0;
         end
         if (clr_in[p]) begin
            req_d[p] = '0;
            req_d[p].rden = 1'b1;
            req_d[p].byteena = `EBR_BE_RST;
         end
      end
   end

   // word position and row of each registered request
   always_comb begin
      logic [5:0] off;
      logic [`EBR_ADDR_W-1:0] wa;
      off = '0;
      wa = '0;
      for (int p = 0; p < `EBR_PORTS; p++) begin
         off = 6'(req_q[p].addr & ((`EBR_ADDR_W'(1) << shape_lg) - `EBR_ADDR_W'(1)));
         pos[p] = 6'(off * shape_bits);
         wa = req_q[p].addr >> shape_lg;
         if (cfg.split) begin
            row[p] = {1'(p), wa[`EBR_HALF_AW-1:0]};
         end else begin
            row[p] = wa[`EBR_ROW_AW-1:0];
         end
      end
   end

   // lane enables moved to the lanes that the word occupies; words under 16 bits enable all lanes
   always_comb begin
      logic [2:0] lane0;
      lane0 = '0;
      for (int p = 0; p < `EBR_PORTS; p++) begin
         lane0 = shape_par ? 3'(pos[p] / `EBR_LANE_W) : 3'(pos[p] / `EBR_BYTE_W);
         if (lane_ok) begin
            be_eff[p] = `EBR_LANES'(req_q[p].byteena << lane0);
         end else begin
            be_eff[p] = `EBR_BE_RST;
         end
      end
   end

   // write mask, merged row and write enable
   always_comb begin
      for (int p = 0; p < `EBR_PORTS; p++) begin
         if (shape_par) begin
            mask[p] = (word_mask << pos[p]) & lane_mask(be_eff[p]);
            data[p] = req_q[p].din << pos[p];
         end else begin
            mask[p] = spread(`EBR_DATA_W'(word_mask) << pos[p]) & lane_mask(be_eff[p]);
            data[p] = spread(req_q[p].din[`EBR_DATA_W-1:0] << pos[p]);
         end
         // strobe alone decides, mask only narrows
         we[p] = req_q[p].wren;
         new_row[p] = (mem_q[row[p]] & ~mask[p]) | (data[p] & mask[p]);
      end
   end

   // read path: the word each port shows after this edge
   always_comb begin
      logic [`EBR_ROW_W-1:0] rd_row;
      logic [`EBR_ROW_W-1:0] fresh;
      rd_row = '0;
      fresh = '0;
      for (int p = 0; p < `EBR_PORTS; p++) begin
         // a write shows its own word on the output
         rd_row = we[p] ? new_row[p] : mem_q[row[p]];
         if (shape_par) begin
            fresh = (rd_row >> pos[p]) & word_mask;
         end else begin
            fresh = `EBR_ROW_W'(squeeze(rd_row) >> pos[p]) & word_mask;
         end
         // write has priority, a read alone reads
         if (we[p] || req_q[p].rden) begin
            comb_val[p] = fresh;
         end else begin
            comb_val[p] = hold_q[p];
         end
      end
   end

   // next value of the output registers
   always_comb begin
      for (int p = 0; p < `EBR_PORTS; p++) begin
         if (clr_out[p]) begin
            hold_d[p] = `EBR_DOUT_RST;
            out_d[p] = `EBR_DOUT_RST;
         end else begin
            hold_d[p] = comb_val[p];
            out_d[p] = comb_val[p];
         end
      end
   end

   // registered or flow-through output
   always_comb begin
      for (int p = 0; p < `EBR_PORTS; p++) begin
         if (cfg.out_reg) begin
            dout[p] = out_q[p];
         end else if (clr_out[p]) begin
            dout[p] = `EBR_DOUT_RST;
         end else begin
            dout[p] = comb_val[p];
         end
      end
   end

   // input registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int p = 0; p < `EBR_PORTS; p++) begin
            req_q[p] <= '0;
            req_q[p].byteena <= `EBR_BE_RST;
         end
      end else begin
         req_q <= req_d;
      end
   end

   // output registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int p = 0; p < `EBR_PORTS; p++) begin
            hold_q[p] <= `EBR_DOUT_RST;
            out_q[p] <= `EBR_DOUT_RST;
         end
      end else begin
         hold_q <= hold_d;
         out_q <= out_d;
      end
   end

   // storage keeps its contents through reset
   // halves never share a row, reads see stored data
   always_ff @(posedge clk) begin
      for (int p = 0; p < `EBR_PORTS; p++) begin
         if (we[p]) begin
            mem_q[row[p]] <= new_row[p];
         end
      end
   end

endmodule
`default_nettype wire

// file: ebr_sp_assertions.sv
// concurrent checks on the block ram ports
`default_nettype none
module ebr_sp_assertions (
   input wire logic clk,
   input wire logic resetn,
   input wire ebr_pkg::ebr_cfg_type cfg,
   input wire ebr_pkg::ebr_req_type [1:0] req,
   input wire logic [1:0] clr_in,
   input wire logic [1:0] clr_out,
   input wire logic [1:0][35:0] dout
);
   timeunit 1ns;
   timeprecision 1ps;
   wire ebr_pkg::ebr_req_type r0 = req[0];
   wire ebr_pkg::ebr_req_type r1 = req[1];
   wire q0 = !clr_in[0] && !clr_out[0];
   wire x36 = cfg.width == ebr_pkg::EBR_X36;
   wire w0 = x36 && r0.wren && r0.byteena == 4'hF && q0;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_pwr;
      $rose(resetn) |-> (dout == '0) [*2];
   endproperty
   a_pwr: assert property (p_pwr) else $error("dout not zero after reset");
   property p_flow;
      !cfg.out_reg && w0 ##1 !clr_out[0] |-> dout[0] == $past(r0.din);
   endproperty
   a_flow: assert property (p_flow) else $error("write data not flowing through");
   property p_split;
      cfg.split && !cfg.out_reg && x36 && r1.wren && r1.byteena == 4'hF && !clr_in[1] && !clr_out[1]
         ##1 !clr_out[1] |-> dout[1] == $past(r1.din);
   endproperty
   a_split: assert property (p_split) else $error("second half port wrong");
   property p_oreg;
      cfg.out_reg && w0 ##1 !clr_out[0] |=> dout[0] == $past(r0.din, 2);
   endproperty
   a_oreg: assert property (p_oreg) else $error("registered output latency wrong");
   property p_clr;
      clr_out[0] && !cfg.out_reg |-> dout[0] == '0;
   endproperty
   a_clr: assert property (p_clr) else $error("output clear not zero");
   property p_hold;
      !cfg.out_reg && !r0.wren && !r0.rden && q0 ##1 !clr_out[0] && $stable(cfg) |-> $stable(dout[0]);
   endproperty
   a_hold: assert property (p_hold) else $error("dout changed without access");
   property p_narrow;
      cfg.width == ebr_pkg::EBR_X8 && !cfg.out_reg && r0.wren && q0 ##1 !clr_out[0]
         |-> dout[0] == {28'h0, $past(r0.din[7:0])};
   endproperty
   a_narrow: assert property (p_narrow) else $error("narrow write wrong");
   property p_rdnew;
      !cfg.out_reg && w0 ##1 r0.rden && !r0.wren && r0.addr == $past(r0.addr) && q0 ##1 !clr_out[0]
         |-> dout[0] == $past(r0.din, 2);
   endproperty
   a_rdnew: assert property (p_rdnew) else $error("read after write wrong");
endmodule
`default_nettype wire

// file: ebr_user.sv
// fabric-side user logic model for one request port
`default_nettype none
module ebr_user (
   input wire ebr_pkg::ebr_req_type want,
   output var ebr_pkg::ebr_req_type req
);
   timeunit 1ns;
   timeprecision 1ps;
   always_comb begin
      req = want;
      if (want.wren) begin
         req.rden = 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: ebr_sp_tb.sv
// self-checking bench for the single-port block ram
`default_nettype none
module ebr_sp_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0;
   logic resetn = 0;
   ebr_pkg::ebr_cfg_type cfg;
   ebr_pkg::ebr_req_type [1:0] w;
   wire ebr_pkg::ebr_req_type [1:0] req;
   logic [1:0] clr_in = 0;
   logic [1:0] clr_out = 0;
   logic [1:0][35:0] dout;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;
   ebr_user u0 (.want(w[0]), .req(req[0]));
   ebr_user u1 (.want(w[1]), .req(req[1]));
   ebr_sp ebr_sp_i (.clk(clk), .resetn(resetn), .cfg(cfg), .req(req), .clr_in(clr_in), .clr_out(clr_out),
      .dout(dout));
   always #2 clk = ~clk;
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 2000) begin
         bad_count++;
         complete_run();
      end
   end
   task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one request for one cycle, entered and left at a falling edge
   task automatic op(input int p, input logic we, input logic rd, input logic [11:0] a, input logic [35:0] d,
      input logic [3:0] be);
      w[p] = '{addr: a, din: d, wren: we, rden: rd, byteena: be};
      @(negedge clk);
   endtask
   task automatic t_wide();
      op(0, 1, 0, 0, 36'hF_FFFF_FFFF, 4'hF);
      cmp(dout[0], 36'hF_FFFF_FFFF);
      op(0, 0, 1, 0, 36'h0, 4'h0);
      op(0, 1, 0, 0, 36'h0, 4'h5);
      op(0, 0, 0, 0, 36'hF_FFFF_FFFF, 4'hF);
      op(0, 0, 1, 0, 36'h0, 4'h0);
      cmp(dout[0], 36'hF_F803_FE00);
      clr_out[0] = 1;
      op(0, 0, 0, 0, 36'h0, 4'h0);
      cmp(dout[0], 36'h0);
      clr_out[0] = 0;
      clr_in[0] = 1;
      op(0, 0, 0, 0, 36'h0, 4'h0);
      clr_in[0] = 0;
      cmp(dout[0], 36'hF_F803_FE00);
      $display("test wide done");
   endtask
   task automatic t_narrow();
      cfg.width = ebr_pkg::EBR_X16;
      op(0, 1, 0, 0, 36'hFFFF, 4'hF);
      op(0, 1, 0, 0, 36'h0, 4'h1);
      op(0, 0, 1, 0, 36'h0, 4'h0);
      cmp(dout[0], 36'hFF00);
      cfg.width = ebr_pkg::EBR_X8;
      op(0, 1, 0, 5, 36'hA5, 4'h0);
      op(0, 0, 1, 5, 36'h0, 4'h0);
      cmp(dout[0], 36'hA5);
      $display("test narrow done");
   endtask
   // parity, one-bit and 32-bit shapes, then a reset that keeps the stored data
   task automatic t_shapes();
      cfg = '{width: ebr_pkg::EBR_X18, split: 1'b0, out_reg: 1'b0};
      op(0, 1, 0, 3, 36'h3_FFFF, 4'h3);
      op(0, 1, 0, 3, 36'h0, 4'h2);
      op(0, 0, 1, 3, 36'h0, 4'h0);
      cmp(dout[0], 36'h1FF);
      cfg.width = ebr_pkg::EBR_X9;
      op(0, 1, 0, 2, 36'h1AB, 4'h0);
      op(0, 0, 1, 2, 36'h0, 4'h0);
      cmp(dout[0], 36'h1AB);
      cfg.width = ebr_pkg::EBR_X1;
      op(0, 1, 0, 7, 36'h1, 4'h0);
      op(0, 0, 1, 7, 36'h0, 4'h0);
      cmp(dout[0], 36'h1);
      cfg.width = ebr_pkg::EBR_X32;
      op(0, 1, 0, 4, 36'hFFFF_FFFF, 4'hF);
      op(0, 1, 0, 4, 36'h0, 4'h8);
      op(0, 0, 1, 4, 36'h0, 4'h0);
      cmp(dout[0], 36'h0_00FF_FFFF);
      resetn = 0;
      op(0, 0, 0, 0, 36'h0, 4'h0);
      resetn = 1;
      op(0, 0, 0, 0, 36'h0, 4'h0);
      op(0, 0, 0, 0, 36'h0, 4'h0);
      cmp(dout[0], 36'h0);
      op(0, 0, 1, 4, 36'h0, 4'h0);
      cmp(dout[0], 36'h0_00FF_FFFF);
      $display("test shapes done");
   endtask
   task automatic t_oreg();
      cfg = '{width: ebr_pkg::EBR_X36, split: 1'b0, out_reg: 1'b1};
      clr_out[0] = 1;
      op(0, 0, 0, 0, 36'h0, 4'h0);
      clr_out[0] = 0;
      op(0, 1, 0, 9, 36'h5_A5A5_A5A5, 4'hF);
      cmp(dout[0], 36'h0);
      op(0, 0, 0, 0, 36'h0, 4'h0);
      cmp(dout[0], 36'h5_A5A5_A5A5);
      $display("test output register done");
   endtask
   task automatic t_split();
      cfg = '{width: ebr_pkg::EBR_X36, split: 1'b1, out_reg: 1'b0};
      fork
         op(0, 1, 0, 1, 36'h1_1111_1111, 4'hF);
         op(1, 1, 0, 1, 36'h2_2222_2222, 4'hF);
      join
      fork
         op(0, 0, 1, 1, 36'h0, 4'h0);
         op(1, 0, 1, 1, 36'h0, 4'h0);
      join
      cmp(dout[0], 36'h1_1111_1111);
      cmp(dout[1], 36'h2_2222_2222);
      $display("test split done");
   endtask
   initial begin
      cfg = '{width: ebr_pkg::EBR_X36, split: 1'b0, out_reg: 1'b0};
      w = '0;
      repeat (4) @(negedge clk);
      resetn = 1;
      repeat (3) @(negedge clk);
      cmp(dout[0], 36'h0);
      cmp(dout[1], 36'h0);
      $display("test reset done");
      t_wide();
      t_narrow();
      t_shapes();
      t_oreg();
      t_split();
      complete_run();
   end
endmodule
bind ebr_sp ebr_sp_assertions ebr_sp_assertions_i (.clk(clk), .resetn(resetn), .cfg(cfg), .req(req),
   .clr_in(clr_in), .clr_out(clr_out), .dout(dout));
`default_nettype wire
